// >>> design/pcs_pkg.sv
/*
  constants for the position command shaping stage: register map,
  reset values, setting limits and timing counts.
  assumes a 50 MHz system clock.
*/
package pcs_pkg;
  // register offsets
  localparam logic [15:0] ADR_SMOOTH = 16'h0110;
  localparam logic [15:0] ADR_ACCEL = 16'h0144;
  localparam logic [15:0] ADR_DECEL = 16'h0146;
  localparam logic [15:0] ADR_SCURVE = 16'h0148;
  localparam logic [15:0] ADR_NUM1 = 16'h0158;
  localparam logic [15:0] ADR_DEN = 16'h015A;
  localparam logic [15:0] ADR_NUMX = 16'h0178;
  localparam logic [15:0] ADR_STATUS = 16'h0180;
  localparam logic [15:0] ADR_GPOS = 16'h0184;
  // reset values
  localparam logic [15:0] SMOOTH_RST = 16'h0000;
  localparam logic [15:0] RAMP_RST = 16'h00C8;
  localparam logic [15:0] SCURVE_RST = 16'h0000;
  localparam logic [31:0] NUM_RST = 32'h0000_0080;
  localparam logic [31:0] DEN_RST = 32'h0000_000A;
  // setting limits
  localparam logic [15:0] RAMP_MIN = 16'h0001;
  localparam logic [15:0] RAMP_MAX = 16'hFFDC;
  localparam logic [15:0] SMOOTH_MAX = 16'h03E8;
  localparam logic [31:0] NUM_MAX = 32'h1FFF_FFFF;
  localparam logic [31:0] DEN_MAX = 32'h7FFF_FFFF;
  localparam logic [15:0] ANA_RAMP_MAX = 16'h4E20;
  localparam logic [15:0] ANA_SCURVE_MAX = 16'h2710;
  // status bit positions
  localparam int ST_REJECT = 0;
  localparam int ST_RAMPING = 1;
  // speed scale: rated motor speed in command units
  localparam logic [15:0] RATED_SPEED = 16'h03E8;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int MS_US = 1000;
  localparam int MS_CYC = MS_US * CLK_MHZ;
  localparam int SMOOTH_UNIT_MS = 10;
  localparam int STEP_CYC = MS_CYC / 1000;
  localparam int SC_UNIT_CYC = MS_CYC / 16;
  localparam int FILT_UNIT_CYC = SMOOTH_UNIT_MS * MS_CYC / 16;
endpackage

// >>> design/position_command_shaping.sv
/*
  position command shaping: speed ramp with s-curve stage, electronic
  gear with carried remainder, position command low-pass stage.
  assumes pins i_CMD_PULSE, i_CMD_DIR, i_SERVO_ON, i_PR_MODE, i_ANALOG_SRC
  and i_GEAR_SEL are asynchronous; register port on I_CLK.
*/
// Implementation choice: the strobed register port.
// Behaviour
// [RULE1] accel ramp zero to rated, default 200
// [RULE2] decel ramp rated to zero, same range
// [RULE3] s-curve zero keeps both ramps active
// [RULE4] total time is ramp plus s-curve
// [RULE5] s-curve constant in ms, default zero
// [RULE6] analog source limits accel to 20000
// [RULE7] analog source limits decel to 20000
// [RULE8] analog source limits s-curve to 10000
// [RULE9] first numerator 32 bit, default 128
// [RULE10] denominator 32 bit, default 10
// [RULE11] numerator writable: pulse on, register off
// [RULE12] denominator locked while drive enabled
// [RULE13] ratio kept within 1/50 and 25600; writes are not checked against the ratio
// [RULE14] output pulses equal input times ratio
// [RULE15] extra numerators share one denominator
// [RULE16] smoothing constant in 10 ms steps
// [RULE17] gear remainder carried, nothing lost
// [RULE18] smoothing zero passes command unfiltered
`timescale 1ns/1ps
`default_nettype none
module position_command_shaping #(
  parameter int MS_CYCLES = pcs_pkg::MS_CYC,
  parameter int FILT_CYCLES = pcs_pkg::FILT_UNIT_CYC
) (
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  input wire logic [15:0] i_ADDR,
  input wire logic [31:0] i_WDATA,
  input wire logic i_WR,
  input wire logic i_RD,
  input wire logic i_CMD_PULSE,
  input wire logic i_CMD_DIR,
  input wire logic i_SERVO_ON,
  input wire logic i_PR_MODE,
  input wire logic i_ANALOG_SRC,
  input wire logic [1:0] i_GEAR_SEL,
  input wire logic [15:0] i_SPEED_TARGET,
  output logic [31:0] o_RDATA,
  output logic o_STEP_PULSE,
  output logic o_STEP_DIR,
  output logic [31:0] o_POS_CMD,
  output logic [15:0] o_SPEED_CMD
);
  import pcs_pkg::*;

  // one step of a smoothing stage: 1/16 of the gap, at least one unit
  function automatic logic [31:0] approach(input logic [31:0] cur,
                                           input logic [31:0] tgt);
    logic [31:0] diff;
    logic [31:0] part;
    diff = tgt - cur;
    part = $signed(diff) >>> 4;
    if (diff == 32'h0000_0000)
      approach = cur;
    else if (part == 32'h0000_0000)
      approach = diff[31] ? cur - 32'h1 : cur + 32'h1;
    else if (part == 32'hFFFF_FFFF && !diff[31])
      approach = cur + 32'h1;
    else
      approach = cur + part;
  endfunction

  // clamp used by the analog source limits
  function automatic logic [15:0] lim(input logic [15:0] v,
                                      input logic [15:0] mx,
                                      input logic on);
    lim = (on && v > mx) ? mx : v;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [6:0] sync1_reg; // first stage, read only by sync2
  logic [6:0] sync2_reg; // stable copies
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end
    else
    begin
      sync1_reg <= {i_GEAR_SEL, i_ANALOG_SRC, i_PR_MODE, i_SERVO_ON,
                    i_CMD_DIR, i_CMD_PULSE};
      sync2_reg <= sync1_reg;
    end
  end
  logic pulse_s; // command pulse level
  logic dir_s; // reverse when high
  logic servo_on_s; // drive enabled
  logic pr_mode_s; // register position mode, else pulse train
  logic analog_s; // speed command from analog source
  logic [1:0] gear_sel_s; // numerator select
  assign pulse_s = sync2_reg[0];
  assign dir_s = sync2_reg[1];
  assign servo_on_s = sync2_reg[2];
  assign pr_mode_s = sync2_reg[3];
  assign analog_s = sync2_reg[4];
  assign gear_sel_s = sync2_reg[6:5];

  //////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] smooth_reg; // low-pass constant, 10 ms units
  logic [15:0] accel_reg; // acceleration time, ms
  logic [15:0] decel_reg; // deceleration time, ms
  logic [15:0] scurve_reg; // s-curve constant, ms
  logic [31:0] num_reg [4]; // numerators, index 0 is the first
  logic [31:0] den_reg; // common denominator
  logic reject_reg; // last write to a mapped register refused; unmapped writes leave it
  logic num_wr_ok; // numerator write window
  logic den_wr_ok; // denominator write window
  logic wr_hit; // write landed on a register
  logic wr_bad; // write refused
  logic [15:0] w16; // low half of write data
  assign w16 = i_WDATA[15:0];
  // pulse mode needs servo on, register mode needs servo off
  assign num_wr_ok = pr_mode_s ? !servo_on_s : servo_on_s; // [RULE11]
  assign den_wr_ok = !servo_on_s; // [RULE12]

  // acceptance of each write; out-of-range values are refused too
  always_comb
  begin
    wr_hit = 1'b1;
    wr_bad = 1'b0;
    unique case (i_ADDR)
      ADR_SMOOTH: wr_bad = w16 > SMOOTH_MAX; // [RULE16]
      ADR_ACCEL, ADR_DECEL: wr_bad = w16 < RAMP_MIN || w16 > RAMP_MAX;
      ADR_SCURVE: wr_bad = w16 > RAMP_MAX; // [RULE5]
      ADR_NUM1, ADR_NUMX, ADR_NUMX + 16'h2, ADR_NUMX + 16'h4:
        wr_bad = !num_wr_ok || i_WDATA == 32'h0 || i_WDATA > NUM_MAX;
      ADR_DEN:
        wr_bad = !den_wr_ok || i_WDATA == 32'h0 || i_WDATA > DEN_MAX;
      default: wr_hit = 1'b0;
    endcase
  end

  // settings storage; a refused write leaves the value untouched
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      smooth_reg <= SMOOTH_RST;
      accel_reg <= RAMP_RST; // [RULE1]
      decel_reg <= RAMP_RST; // [RULE2]
      scurve_reg <= SCURVE_RST; // [RULE5]
      num_reg[0] <= NUM_RST; // [RULE9]
      num_reg[1] <= NUM_RST;
      num_reg[2] <= NUM_RST;
      num_reg[3] <= NUM_RST;
      den_reg <= DEN_RST; // [RULE10]
      reject_reg <= 1'b0;
    end
    else if (i_WR && wr_hit)
    begin
      reject_reg <= wr_bad;
      if (!wr_bad)
      begin
        unique case (i_ADDR)
          ADR_SMOOTH: smooth_reg <= w16;
          ADR_ACCEL: accel_reg <= w16;
          ADR_DECEL: decel_reg <= w16;
          ADR_SCURVE: scurve_reg <= w16;
          ADR_NUM1: num_reg[0] <= i_WDATA;
          ADR_NUMX: num_reg[1] <= i_WDATA; // [RULE15]
          ADR_NUMX + 16'h2: num_reg[2] <= i_WDATA;
          ADR_NUMX + 16'h4: num_reg[3] <= i_WDATA;
          ADR_DEN: den_reg <= i_WDATA;
          default: reject_reg <= 1'b0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // effective ramp settings, limited under an analog source
  logic [15:0] eff_acc; // acceleration time in use
  logic [15:0] eff_dec; // deceleration time in use
  logic [15:0] eff_tsl; // s-curve time in use
  assign eff_acc = lim(accel_reg, ANA_RAMP_MAX, analog_s); // [RULE6]
  assign eff_dec = lim(decel_reg, ANA_RAMP_MAX, analog_s); // [RULE7]
  assign eff_tsl = lim(scurve_reg, ANA_SCURVE_MAX, analog_s); // [RULE8]

  //////////////////////////////////////////////////////////////////////
  // linear speed ramp: one unit per time/rated, so rated in full time
  logic [15:0] speed_reg; // ramp output
  logic [31:0] ramp_cnt_reg; // cycles since last unit step
  logic [31:0] up_period; // cycles per unit when rising
  logic [31:0] dn_period; // cycles per unit when falling
  logic [15:0] tgt_lim; // target held to rated speed
  logic going_up; // ramp direction
  logic ramp_end; // period elapsed
  assign tgt_lim = i_SPEED_TARGET > RATED_SPEED ? RATED_SPEED
                                                 : i_SPEED_TARGET;
  assign up_period = 32'(eff_acc) * 32'(MS_CYCLES / 1000); // [RULE1]
  assign dn_period = 32'(eff_dec) * 32'(MS_CYCLES / 1000); // [RULE2]
  assign going_up = tgt_lim > speed_reg;
  assign ramp_end = ramp_cnt_reg + 32'h1 >=
                    (going_up ? up_period : dn_period);

  // ramps stay in force whatever the s-curve setting holds
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      speed_reg <= 16'h0000;
      ramp_cnt_reg <= 32'h0;
    end
    else if (tgt_lim == speed_reg)
      ramp_cnt_reg <= 32'h0; // idle, next move starts a full period
    else if (ramp_end)
    begin
      ramp_cnt_reg <= 32'h0;
      speed_reg <= going_up ? speed_reg + 16'h1
                            : speed_reg - 16'h1; // [RULE1] [RULE2] [RULE3]
    end
    else
      ramp_cnt_reg <= ramp_cnt_reg + 32'h1;
  end

  //////////////////////////////////////////////////////////////////////
  // s-curve stage: smoothing with time constant eff_tsl, which rounds
  // the ramp corners and stretches each ramp by about eff_tsl
  logic [31:0] sc_cnt_reg; // cycles to next smoothing step
  logic [15:0] sspeed_reg; // smoothed speed
  logic [31:0] sc_period; // cycles per smoothing step
  logic [31:0] sc_step; // next smoothed value
  assign sc_period = 32'(eff_tsl) * 32'(MS_CYCLES / 16); // [RULE4]
  assign sc_step = approach(32'(sspeed_reg), 32'(speed_reg));

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      sc_cnt_reg <= 32'h0;
      sspeed_reg <= 16'h0000;
    end
    else if (eff_tsl == 16'h0000)
    begin
      sc_cnt_reg <= 32'h0;
      sspeed_reg <= speed_reg; // [RULE3]
    end
    else if (sc_cnt_reg + 32'h1 >= sc_period)
    begin
      sc_cnt_reg <= 32'h0;
      sspeed_reg <= sc_step[15:0]; // [RULE4]
    end
    else
      sc_cnt_reg <= sc_cnt_reg + 32'h1;
  end

  //////////////////////////////////////////////////////////////////////
  // electronic gear: rate-multiplier accumulator. input edges add the
  // numerator, each output step removes one denominator. at most one
  // step per clock; a high ratio builds a backlog that drains later,
  // the remainder is never dropped.
  logic pulse_d_reg; // previous pulse level
  logic [33:0] acc_reg; // remainder, sized for legal ratios [RULE13]
  logic [33:0] acc_sum; // accumulator after this cycle's edge
  logic [33:0] den_x; // denominator widened
  logic [31:0] num_sel; // numerator in use
  logic step_fwd; // forward output step
  logic step_rev; // reverse output step
  logic [31:0] gpos_reg; // geared position
  assign num_sel = num_reg[gear_sel_s]; // [RULE15]
  assign den_x = {2'b00, den_reg};
  always_comb
  begin
    acc_sum = acc_reg;
    if (pulse_s && !pulse_d_reg)
      acc_sum = dir_s ? acc_reg - {2'b00, num_sel}
                      : acc_reg + {2'b00, num_sel}; // [RULE14]
  end
  assign step_fwd = $signed(acc_sum) >= $signed(den_x);
  assign step_rev = $signed(acc_sum) <= -$signed(den_x);

  // remainder carried into the next pulse
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      pulse_d_reg <= 1'b0;
      acc_reg <= 34'h0;
      gpos_reg <= 32'h0;
    end
    else
    begin
      pulse_d_reg <= pulse_s;
      if (step_fwd)
      begin
        acc_reg <= acc_sum - den_x; // [RULE17]
        gpos_reg <= gpos_reg + 32'h1;
      end
      else if (step_rev)
      begin
        acc_reg <= acc_sum + den_x; // [RULE17]
        gpos_reg <= gpos_reg - 32'h1;
      end
      else
        acc_reg <= acc_sum; // [RULE17]
    end
  end

  //////////////////////////////////////////////////////////////////////
  // low-pass stage on the geared position
  logic [31:0] filt_cnt_reg; // cycles to next filter step
  logic [31:0] filt_period; // cycles per filter step
  logic [31:0] filt_step; // next filtered value
  assign filt_period = 32'(smooth_reg) * 32'(FILT_CYCLES); // [RULE16]
  assign filt_step = approach(o_POS_CMD, gpos_reg);

  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      filt_cnt_reg <= 32'h0;
      o_POS_CMD <= 32'h0;
    end
    else if (smooth_reg == 16'h0000)
    begin
      filt_cnt_reg <= 32'h0;
      o_POS_CMD <= gpos_reg; // [RULE18]
    end
    else if (filt_cnt_reg + 32'h1 >= filt_period)
    begin
      filt_cnt_reg <= 32'h0;
      o_POS_CMD <= filt_step; // [RULE16]
    end
    else
      filt_cnt_reg <= filt_cnt_reg + 32'h1;
  end

  //////////////////////////////////////////////////////////////////////
  // outputs and read port; read data stand for one cycle only
  always_ff @(posedge I_CLK)
  begin
    if (I_SYS_RST)
    begin
      o_STEP_PULSE <= 1'b0;
      o_STEP_DIR <= 1'b0;
      o_SPEED_CMD <= 16'h0000;
      o_RDATA <= 32'h0;
    end
    else
    begin
      o_STEP_PULSE <= step_fwd || step_rev; // [RULE14]
      o_STEP_DIR <= step_rev;
      o_SPEED_CMD <= sspeed_reg;
      o_RDATA <= 32'h0;
      if (i_RD)
      begin
        unique case (i_ADDR)
          ADR_SMOOTH: o_RDATA <= 32'(smooth_reg);
          ADR_ACCEL: o_RDATA <= 32'(eff_acc);
          ADR_DECEL: o_RDATA <= 32'(eff_dec);
          ADR_SCURVE: o_RDATA <= 32'(eff_tsl);
          ADR_NUM1: o_RDATA <= num_reg[0];
          ADR_NUMX: o_RDATA <= num_reg[1];
          ADR_NUMX + 16'h2: o_RDATA <= num_reg[2];
          ADR_NUMX + 16'h4: o_RDATA <= num_reg[3];
          ADR_DEN: o_RDATA <= den_reg;
          ADR_STATUS: o_RDATA <= 32'({speed_reg != tgt_lim, reject_reg});
          ADR_GPOS: o_RDATA <= gpos_reg;
          default: o_RDATA <= 32'h0; // unmapped reads zero
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  AST_ACC_UP: assert property ( // [RULE1]
    speed_reg == $past(speed_reg) + 16'h1 |->
    $past(ramp_cnt_reg) + 32'h1 >= $past(up_period))
    else $error("speed rose before accel period");
  AST_DEC_DN: assert property ( // [RULE2]
    speed_reg + 16'h1 == $past(speed_reg) |->
    $past(ramp_cnt_reg) + 32'h1 >= $past(dn_period))
    else $error("speed fell before decel period");
  AST_SC_OFF: assert property ( // [RULE3]
    eff_tsl == 16'h0000 |=> sspeed_reg == $past(speed_reg))
    else $error("s-curve off but speed not passed");
  AST_SC_HOLD: assert property ( // [RULE4]
    eff_tsl != 16'h0000 && sc_cnt_reg != 32'h0 && $stable(eff_tsl)
    && sc_cnt_reg + 32'h1 < sc_period |=> $stable(sspeed_reg))
    else $error("s-curve stepped early");
  AST_ANA_ACC: assert property ( // [RULE6]
    analog_s |-> eff_acc <= ANA_RAMP_MAX && eff_dec <= ANA_RAMP_MAX)
    else $error("analog ramp limit exceeded");
  AST_ANA_SC: assert property ( // [RULE8]
    analog_s |-> eff_tsl <= ANA_SCURVE_MAX)
    else $error("analog s-curve limit exceeded");
  AST_NUM_LOCK: assert property ( // [RULE11]
    num_reg[0] != $past(num_reg[0]) |-> $past(num_wr_ok && i_WR))
    else $error("numerator changed outside window");
  AST_DEN_LOCK: assert property ( // [RULE12]
    den_reg != $past(den_reg) |-> !$past(servo_on_s))
    else $error("denominator changed while enabled");
  AST_STEP_POS: assert property ( // [RULE14]
    o_STEP_PULSE && !o_STEP_DIR |-> gpos_reg == $past(gpos_reg) + 32'h1)
    else $error("forward step not counted");
  AST_REM_KEPT: assert property ( // [RULE17]
    !(pulse_s && !pulse_d_reg) && !step_fwd && !step_rev |=>
    acc_reg == $past(acc_reg))
    else $error("gear remainder lost");
  AST_LPF_PASS: assert property ( // [RULE18]
    smooth_reg == 16'h0000 |=> o_POS_CMD == $past(gpos_reg))
    else $error("unfiltered path not taken");
  AST_LPF_MAX: assert property ( // [RULE16]
    smooth_reg <= SMOOTH_MAX)
    else $error("smoothing constant out of range");

  COV_RAMP_UP: cover property (speed_reg == RATED_SPEED);
  COV_REJECT: cover property (i_WR && wr_hit && wr_bad);
  COV_REV_STEP: cover property (o_STEP_PULSE && o_STEP_DIR);
  COV_FILT: cover property (smooth_reg != 16'h0 && o_POS_CMD != gpos_reg);
endmodule // position_command_shaping
`default_nettype wire

// >>> testbench/pulse_source.sv
/*
  pulse source: model of the motion controller that drives the step
  and direction pins. assumes i_go is a one-cycle request given only
  while o_busy is low.
*/
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [7:0] i_count,
  input wire logic i_rev,
  output logic o_pulse,
  output logic o_dir,
  output logic o_busy
);
  logic [7:0] left_reg = 8'h00; // pulses still to send
  logic [2:0] ph_reg = 3'h0; // phase: 0..2 low, 3..5 high
  logic dir_reg = 1'b0; // held for the whole frame
  //////////////////////////////////////////////////////////////////////
  // three cycles low then three high, above the two-cycle minimum;
  // the low phase first gives direction setup before the first edge
  always_ff @(posedge i_clk)
  begin
    if (i_go)
    begin
      left_reg <= i_count;
      dir_reg <= i_rev;
      ph_reg <= 3'h0;
    end
    else if (left_reg != 8'h00)
    begin
      ph_reg <= (ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
      if (ph_reg == 3'h5)
        left_reg <= left_reg - 8'h01;
    end
  end
  // line idles low between frames
  assign o_pulse = (left_reg != 8'h00) && (ph_reg >= 3'h3);
  assign o_dir = dir_reg;
  assign o_busy = (left_reg != 8'h00);
endmodule // pulse_source
`default_nettype wire

// >>> testbench/test_position_command_shaping.sv
/*
  self-checking bench for the position command shaping stage.
  assumes the design package is compiled first; short ms and filter
  counts are set so that ramps stay within the run budget.
*/
`timescale 1ns/1ps
`default_nettype none
module test_position_command_shaping;
  import pcs_pkg::*;
  logic clk = 1'b0; // 50 MHz
  logic rst = 1'b1; // sync, active high
  logic [15:0] addr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic servo = 1'b0;
  logic pr = 1'b0; // low: pulse train mode
  logic ana = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [15:0] tgt = 16'h0000;
  logic go = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic rev = 1'b0;
  logic pulse, dir, busy, step, step_dir;
  logic [31:0] rdata, pos_cmd;
  logic [15:0] speed, s;
  logic [31:0] steps = 32'h0000_0000; // net steps seen at the pins
  logic [31:0] rv; // last read value
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int n, c;
  // reset value table
  localparam logic [15:0] RST_A [9] = '{ADR_SMOOTH, ADR_ACCEL, ADR_DECEL,
    ADR_SCURVE, ADR_NUM1, ADR_DEN, ADR_NUMX, ADR_NUMX + 16'h0002,
    ADR_NUMX + 16'h0004};
  localparam logic [31:0] RST_V [9] = '{32'h0, 32'hC8, 32'hC8, 32'h0,
    32'h80, 32'hA, 32'h80, 32'h80, 32'h80};
  //////////////////////////////////////////////////////////////////////
  position_command_shaping #(.MS_CYCLES(1000), .FILT_CYCLES(16))
    position_command_shaping_i (.I_CLK(clk), .I_SYS_RST(rst),
    .i_ADDR(addr), .i_WDATA(wdata), .i_WR(wr), .i_RD(rd),
    .i_CMD_PULSE(pulse), .i_CMD_DIR(dir), .i_SERVO_ON(servo),
    .i_PR_MODE(pr), .i_ANALOG_SRC(ana), .i_GEAR_SEL(sel),
    .i_SPEED_TARGET(tgt), .o_RDATA(rdata), .o_STEP_PULSE(step),
    .o_STEP_DIR(step_dir), .o_POS_CMD(pos_cmd), .o_SPEED_CMD(speed));
  pulse_source pulse_source_i (.i_clk(clk), .i_go(go), .i_count(cnt),
    .i_rev(rev), .o_pulse(pulse), .o_dir(dir), .o_busy(busy));
  //////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    forever #10 clk = ~clk;
  end
  // step counter and hang guard; the run needs about 34000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (step === 1'b1)
      steps <= (step_dir === 1'b1) ? steps - 32'h1 : steps + 32'h1;
    if (cyc == 90000)
    begin
      err_count++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [15:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // write, read back, and check refusal flag (refused when e differs)
  task automatic try(input logic [15:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    wr_reg(a, d);
    rd_reg(a);
    chk(rv, e);
    rd_reg(ADR_STATUS);
    chk(rv[0], e !== d);
  endtask
  // pins pass two sync flops and an edge detect
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  // send k pulses, wait for net step count e, check geared position
  task automatic burst(input logic [7:0] k, input logic r,
                       input logic [31:0] e);
    @(posedge clk);
    cnt <= k;
    rev <= r;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (n = 0; n < 3000 && (busy !== 1'b0 || steps !== e); n++)
      @(negedge clk);
    chk(steps, e);
    rd_reg(ADR_GPOS);
    chk(rv, e);
  endtask
  // cycles until speed reaches t; speed sampled at cycle m
  task automatic ramp(input logic [15:0] t, input int m);
    @(posedge clk);
    tgt <= t;
    for (c = 0; c < 40000 && speed !== t; c++)
    begin
      @(negedge clk);
      if (c == m)
        s = speed;
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++)
    begin
      rd_reg(RST_A[i]);
      chk(rv, RST_V[i]);
    end
    rd_reg(16'h0200);
    chk(rv, 32'h0);
    // limits, pulse train mode with the drive off
    try(ADR_ACCEL, 32'h0, 32'hC8);
    try(ADR_ACCEL, 32'hFFDD, 32'hC8);
    try(ADR_ACCEL, 32'hFFDC, 32'hFFDC);
    try(ADR_DECEL, 32'h0, 32'hC8);
    try(ADR_DECEL, 32'hFFDC, 32'hFFDC);
    try(ADR_SCURVE, 32'hFFDD, 32'h0);
    try(ADR_SCURVE, 32'hFFDC, 32'hFFDC);
    try(ADR_SMOOTH, 32'h3E9, 32'h0);
    try(ADR_SMOOTH, 32'h3E8, 32'h3E8);
    try(ADR_SMOOTH, 32'h0, 32'h0);
    try(ADR_DEN, 32'h0, 32'hA);
    try(ADR_DEN, 32'h8000_0000, 32'hA);
    try(ADR_DEN, 32'h7FFF_FFFF, 32'h7FFF_FFFF);
    try(ADR_DEN, 32'hA, 32'hA);
    try(ADR_NUM1, 32'h5, 32'h80);
    // unmapped write leaves the refusal flag alone
    wr_reg(16'h0200, 32'h1);
    rd_reg(ADR_STATUS);
    chk(rv[0], 1'b1);
    // analog source clamps what is in use, keeps what is stored
    try(ADR_ACCEL, 32'h7530, 32'h7530);
    try(ADR_DECEL, 32'h61A8, 32'h61A8);
    try(ADR_SCURVE, 32'h3A98, 32'h3A98);
    ana <= 1'b1;
    settle();
    rd_reg(ADR_ACCEL);
    chk(rv, 32'h4E20);
    rd_reg(ADR_DECEL);
    chk(rv, 32'h4E20);
    rd_reg(ADR_SCURVE);
    chk(rv, 32'h2710);
    ana <= 1'b0;
    settle();
    rd_reg(ADR_ACCEL);
    chk(rv, 32'h7530);
    // gear windows and scaling with the drive on
    servo <= 1'b1;
    settle();
    try(ADR_DEN, 32'h14, 32'hA);
    try(ADR_NUM1, 32'h0, 32'h80);
    try(ADR_NUM1, 32'h2000_0000, 32'h80);
    try(ADR_NUM1, 32'h1FFF_FFFF, 32'h1FFF_FFFF);
    try(ADR_NUM1, 32'h5, 32'h5);
    burst(8'h07, 1'b0, 32'h3);
    burst(8'h01, 1'b0, 32'h4);
    burst(8'h08, 1'b1, 32'h0);
    try(ADR_NUM1, 32'h1E, 32'h1E);
    burst(8'h02, 1'b0, 32'h6);
    chk(pos_cmd, 32'h6);
    try(ADR_NUMX + 16'h0002, 32'h14, 32'h14);
    sel <= 2'h2;
    settle();
    burst(8'h01, 1'b0, 32'h8);
    sel <= 2'h0;
    // register position mode window is the other way round
    pr <= 1'b1;
    settle();
    try(ADR_NUM1, 32'h7, 32'h1E);
    try(ADR_DEN, 32'h7, 32'hA);
    servo <= 1'b0;
    settle();
    try(ADR_NUM1, 32'hA, 32'hA);
    pr <= 1'b0;
    servo <= 1'b1;
    settle();
    // low-pass lags the geared count, then settles on it
    try(ADR_SMOOTH, 32'h1, 32'h1);
    burst(8'h10, 1'b0, 32'h18);
    chk(pos_cmd < 32'h18, 1'b1);
    for (n = 0; n < 3000 && pos_cmd !== 32'h18; n++)
      @(negedge clk);
    chk(pos_cmd, 32'h18);
    // linear ramps: 10 ms up, 5 ms down, one ms is 1000 cycles
    try(ADR_ACCEL, 32'hA, 32'hA);
    try(ADR_DECEL, 32'h5, 32'h5);
    try(ADR_SCURVE, 32'h0, 32'h0);
    ramp(16'h03E8, 5000);
    chk(c >= 9990 && c <= 10030, 1'b1);
    chk(s >= 16'h01EA && s <= 16'h01FE, 1'b1);
    rd_reg(ADR_STATUS);
    chk(rv[1], 1'b0);
    ramp(16'h0000, 2500);
    chk(c >= 4990 && c <= 5030, 1'b1);
    chk(s >= 16'h01EA && s <= 16'h01FE, 1'b1);
    // s-curve stretches the rise beyond the bare ramp time
    try(ADR_SCURVE, 32'h2, 32'h2);
    tgt <= 16'h03E8;
    rd_reg(ADR_STATUS);
    chk(rv[1], 1'b1);
    ramp(16'h03E8, 10000);
    chk(s < 16'h03E8, 1'b1);
    chk(c >= 11000 && c < 40000, 1'b1);
    end_sim();
  end
endmodule // test_position_command_shaping
`default_nettype wire
